// *** logic/usu_serial_unit.sv ***
`include "usu_params.svh"
`default_nettype none
module usu_serial_unit
   import usu_pkg::*;
(
   input  wire logic       CORE_CLK,
   input  wire logic       RST_N,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       GLOBAL_IE,
   input  wire logic       TIMER_MATCH,
   input  wire logic       SDA_I,
   input  wire logic       SCL_I,
   output usu_pins_t       PINS,
   output logic            PULLUP_SDA,
   output logic            PULLUP_SCL,
   output logic            START_IRQ,
   output logic            OVF_IRQ
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl_r;
   logic       sif_r;
   logic       oif_r;
   logic       pf_r;
   logic [3:0] cnt_r;
   logic [7:0] data_r;
   logic [7:0] buf_r;
   logic [1:0] port_r;
   logic [1:0] dir_r;
   logic       latch_r;
   logic       hold_start_r;
   logic [7:0] rdata_r;
   logic [2:0] sda_s_r;
   logic [2:0] scl_s_r;
   logic       sda_q_r;
   logic       scl_q_r;
   logic       din_prev_r;

   usu_wm_t    wm;
   logic       wr_ctrl;
   logic       clk_strobe;
   logic       tog_strobe;
   logic       sda_v;
   logic       scl_v;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       shift_en;
   logic       count_en;
   logic       wrap;
   logic       two_wire;
   logic       ext_clk;
   logic       msb_out;

   assign wm       = usu_wm_t'(ctrl_r[`USU_B_WMH:`USU_B_WML]);
   assign two_wire = ctrl_r[`USU_B_WMH];
   assign ext_clk  = ctrl_r[`USU_B_CSH];
   assign wr_ctrl  = WR && (ADDR == `USU_ADDR_CTRL);
   // strobes live only in the write cycle; only the clock strobe bit is stored, as select under external clock
   assign clk_strobe = wr_ctrl && WDATA[`USU_B_CLK];
   assign tog_strobe = wr_ctrl && WDATA[`USU_B_TC];

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // inputs sampled in every mode
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         sda_s_r <= 3'h7;
         scl_s_r <= 3'h7;
         sda_q_r <= 1'b1;
         scl_q_r <= 1'b1;
      end
      else
      begin
         sda_s_r <= {sda_s_r[1:0], SDA_I};
         scl_s_r <= {scl_s_r[1:0], SCL_I};
         if (sda_s_r[1] == sda_s_r[2])
            sda_q_r <= sda_s_r[2];
         if (scl_s_r[1] == scl_s_r[2])
            scl_q_r <= scl_s_r[2];
      end
   end
   assign sda_v    = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_q_r;
   assign scl_v    = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_q_r;
   assign scl_rise = scl_v && !scl_q_r;
   assign scl_fall = !scl_v && scl_q_r;
   // outside two-wire modes the start detector fires on every scl edge
   assign start_det = two_wire ? (scl_v && sda_q_r && !sda_v) : (scl_rise || scl_fall);
   assign stop_det  = two_wire && scl_v && !sda_q_r && sda_v;

   // ---------------------------------------------------------------
   // clock selection
   // ---------------------------------------------------------------
   always_comb
   begin
      shift_en = 1'b0;
      count_en = 1'b0;
      if (!ext_clk)
      begin
         if (ctrl_r[`USU_B_CSL])
         begin
            shift_en = TIMER_MATCH;
            count_en = TIMER_MATCH;
         end
         else
         begin
            shift_en = clk_strobe;
            count_en = clk_strobe;
         end
      end
      else
      begin
         shift_en = ctrl_r[`USU_B_CSL] ? scl_fall : scl_rise;
         // stored select picks toggle strobe as counter clock
         count_en = ctrl_r[`USU_B_CLK] ? tog_strobe : (scl_rise || scl_fall);
      end
   end
   assign wrap = count_en && (cnt_r == `USU_CNT_MAX);

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         ctrl_r <= `USU_CTRL_RST;
      else if (wr_ctrl)
      begin
         ctrl_r[7:2] <= WDATA[7:2];
         // strobe bit only kept as select under external clock
         ctrl_r[`USU_B_CLK] <= WDATA[`USU_B_CSH] & WDATA[`USU_B_CLK];
         ctrl_r[`USU_B_TC]  <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // status flags, counter
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         sif_r <= 1'b0;
         oif_r <= 1'b0;
         pf_r  <= 1'b0;
         cnt_r <= 4'h0;
      end
      else
      begin
         // set wins over write-one-to-clear
         if (start_det)
            sif_r <= 1'b1;
         else if (WR && ADDR == `USU_ADDR_STAT && WDATA[`USU_B_SIF])
            sif_r <= 1'b0;
         if (wrap)
            oif_r <= 1'b1;
         else if (WR && ADDR == `USU_ADDR_STAT && WDATA[`USU_B_OIF])
            oif_r <= 1'b0;
         if (stop_det)
            pf_r <= 1'b1;
         else if (WR && ADDR == `USU_ADDR_STAT && WDATA[`USU_B_PF])
            pf_r <= 1'b0;
         if (WR && ADDR == `USU_ADDR_STAT)
            cnt_r <= WDATA[3:0];
         else if (count_en)
            cnt_r <= cnt_r + 4'h1;
      end
   end

   // start hold set on scl fall after a start, released with the flag
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         hold_start_r <= 1'b0;
      else if (!two_wire || !sif_r)
         hold_start_r <= 1'b0;
      else if (scl_fall)
         hold_start_r <= 1'b1;
   end

   // ---------------------------------------------------------------
   // data, buffer and output latch
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         data_r     <= 8'h00;
         buf_r      <= 8'h00;
         din_prev_r <= 1'b0;
      end
      else
      begin
         din_prev_r <= sda_v;
         if (WR && ADDR == `USU_ADDR_DATA)
            data_r <= WDATA; // a write beats a shift in the same cycle
         else if (shift_en)
            // strobe shifts in the value seen the cycle before
            data_r <= {data_r[6:0], ext_clk ? sda_v : din_prev_r};
         if (wrap)
            buf_r <= data_r;
      end
   end

   // latch closes for the sampling half of the serial clock
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         latch_r <= 1'b0;
      else if (!ext_clk || (ctrl_r[`USU_B_CSL] ? scl_v : !scl_v))
         latch_r <= data_r[7];
   end
   // transparent for internal clocks so strobe output shows at once
   assign msb_out = ext_clk ? latch_r : data_r[7];

   // ---------------------------------------------------------------
   // port bits
   // ---------------------------------------------------------------
   // bit 0 is the data pin, bit 1 the clock pin
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         port_r <= 2'h0;
         dir_r  <= 2'h0;
      end
      else
      begin
         if (WR && ADDR == `USU_ADDR_DIR)
            dir_r <= WDATA[1:0];
         if (WR && ADDR == `USU_ADDR_PORT)
            port_r <= WDATA[1:0];
         else if (tog_strobe)
            port_r[1] <= ~port_r[1]; // independent of direction
      end
   end

   // ---------------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------------
   always_comb
   begin
      PINS = '0;
      unique case (wm)
         USU_WM_OFF:
         begin
            // normal port behaviour
            PINS.do_o   = port_r[0];
            PINS.do_oe  = dir_r[0];
            PINS.scl_o  = port_r[1];
            PINS.scl_oe = dir_r[1];
         end
         USU_WM_3W:
         begin
            PINS.do_o   = msb_out;
            PINS.do_oe  = dir_r[0];
            PINS.scl_o  = port_r[1];
            PINS.scl_oe = dir_r[1];
         end
         USU_WM_2W, USU_WM_2WOV:
         begin
            // open drain: only ever drive low
            PINS.sda_o  = 1'b0;
            PINS.sda_oe = dir_r[0] && (!msb_out || !port_r[0]);
            PINS.scl_o  = 1'b0;
            PINS.scl_oe = dir_r[1] && (!port_r[1] || hold_start_r ||
                          (wm == USU_WM_2WOV && oif_r));
         end
      endcase
   end
   // pull-ups off in two-wire modes
   assign PULLUP_SDA = !two_wire && !dir_r[0] && port_r[0];
   assign PULLUP_SCL = !two_wire && !dir_r[1] && port_r[1];

   // level requests track enable and flag, so pending flags fire at once
   assign START_IRQ = GLOBAL_IE && ctrl_r[`USU_B_SIE] && sif_r;
   assign OVF_IRQ   = GLOBAL_IE && ctrl_r[`USU_B_OIE] && oif_r;

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         rdata_r <= 8'h00;
      else if (RD)
      begin
         unique case (ADDR)
            `USU_ADDR_CTRL: rdata_r <= {ctrl_r[7:2], 2'b00};
            `USU_ADDR_STAT: rdata_r <= {sif_r, oif_r, pf_r, msb_out ^ sda_v, cnt_r};
            `USU_ADDR_DATA: rdata_r <= data_r;
            `USU_ADDR_BUF:  rdata_r <= buf_r;
            `USU_ADDR_PORT: rdata_r <= {6'h00, port_r};
            `USU_ADDR_DIR:  rdata_r <= {6'h00, dir_r};
            default:        rdata_r <= 8'h00;
         endcase
      end
   end
   assign RDATA = rdata_r;
endmodule
`default_nettype wire

// *** pkg/usu_params.svh ***
// Summary of operation
// - start irq requested only while start enable (bit 7) and start flag set
// - pending start flag raises irq at once when enable is set
// - overflow irq whenever global enable, overflow enable (bit 6) and overflow flag are one
// - wire mode (bits 5:4) changes outputs and start/stop detection; inputs always sampled
// - mode 00 disables outputs and clock hold; start detector fires on every scl edge
// - three-wire: data output replaces port bit; direction still gates drive
// - three-wire: data in and clock pins sampled without altering port behaviour
// - two-wire: open-drain sda/scl, driver enabled only by direction bit
// - two-wire sda low when data msb or port bit is zero
// - two-wire scl low when port bit zero or hold active
// - after start condition hold scl low until start flag cleared
// - two-wire disables pull-ups on sda and scl, inputs unchanged
// - mode 11 also holds scl low from overflow until overflow flag cleared
// - external clock: output latch changes on edge opposite to sampling
// - strobe or timer clock: output latch transparent
// - clock source (bits 3:2) clocks shift register and counter; 01 is timer
// - source 00 with strobe bit one shifts once and counts once
// - strobe output changes same cycle; shifted bit sampled cycle before
// - external clock: strobe bit is stored select for toggle-clocked counter
// - external shift on rising edge if low bit 0, falling if 1; count both
// - strobe bit always reads zero
// - toggle strobe inverts clock port bit; may clock counter; reads zero
// - counter 15 to 0 sets overflow flag; cleared only by writing one
`ifndef USU_PARAMS_SVH
`define USU_PARAMS_SVH
`define USU_ADDR_CTRL   8'h0D
`define USU_ADDR_STAT   8'h0E
`define USU_ADDR_DATA   8'h0F
`define USU_ADDR_BUF    8'h10
`define USU_ADDR_PORT   8'h11
`define USU_ADDR_DIR    8'h12
`define USU_CTRL_RST    8'h00
`define USU_B_SIE       7
`define USU_B_OIE       6
`define USU_B_WMH       5
`define USU_B_WML       4
`define USU_B_CSH       3
`define USU_B_CSL       2
`define USU_B_CLK       1
`define USU_B_TC        0
`define USU_B_SIF       7
`define USU_B_OIF       6
`define USU_B_PF        5
`define USU_CNT_MAX     4'hF
`endif

// *** pkg/usu_pkg.sv ***
`default_nettype none
package usu_pkg;
   typedef enum logic [1:0] {
      USU_WM_OFF  = 2'b00,
      USU_WM_3W   = 2'b01,
      USU_WM_2W   = 2'b10,
      USU_WM_2WOV = 2'b11
   } usu_wm_t;
   typedef struct packed {
      logic sda_o;
      logic sda_oe;
      logic scl_o;
      logic scl_oe;
      logic do_o;
      logic do_oe;
   } usu_pins_t;
endpackage
`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none
module tb
   import usu_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0] ctl, dir, prt, dat, exp, msk;
   } usu_row_t;
   logic       CORE_CLK = 1'b0;
   logic       RST_N = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic       GLOBAL_IE = 1'b1;
   logic       TIMER_MATCH = 1'b0;
   logic       fm_go = 1'b0;
   logic [7:0] fm_tx = 8'h00;
   logic [7:0] RDATA;
   logic       SDA_I;
   logic       SCL_I;
   usu_pins_t  PINS;
   logic       PULLUP_SDA;
   logic       PULLUP_SCL;
   logic       START_IRQ;
   logic       OVF_IRQ;
   logic       fm_scl;
   logic       fm_sda;
   logic [7:0] pins_v;
   int         n_mismatch = 0;
   int         checks = 0;
   usu_row_t   rows [7] = '{'{8'h20, 8'h01, 8'h01, 8'h80, 8'h00, 8'h0F},
      '{8'h20, 8'h01, 8'h00, 8'h80, 8'h08, 8'h0F}, '{8'h20, 8'h01, 8'h01, 8'h00, 8'h08, 8'h0F},
      '{8'h30, 8'h02, 8'h00, 8'h00, 8'h04, 8'h0F}, '{8'h10, 8'h01, 8'h00, 8'h80, 8'h30, 8'h38},
      '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h38}, '{8'h00, 8'h03, 8'h03, 8'h80, 8'h00, 8'h08}};
   // open drain: a driver enable pulls the line low
   assign SDA_I = fm_sda & !PINS.sda_oe;
   assign SCL_I = fm_scl & !PINS.scl_oe;
   assign pins_v = {2'b00, PINS.do_o, PINS.do_oe, PINS.sda_oe, PINS.scl_oe, PULLUP_SDA, PULLUP_SCL};
   always #50 CORE_CLK = !CORE_CLK;
   usu_serial_unit uut (.CORE_CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .GLOBAL_IE,
      .TIMER_MATCH, .SDA_I, .SCL_I, .PINS, .PULLUP_SDA, .PULLUP_SCL, .START_IRQ, .OVF_IRQ);
   usu_far_master u_far (.go(fm_go), .tx(fm_tx), .scl_in(SCL_I), .scl(fm_scl), .sda(fm_sda));
   // ------
   // bus tasks and checks
   // ------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CORE_CLK);
      WR <= 1'b0;
      @(posedge CORE_CLK);
   endtask
   task automatic rdv(input logic [7:0] a, output logic [7:0] d);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      @(posedge CORE_CLK);
      d = RDATA;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      logic [7:0] d;
      rdv(a, d);
      chk(d & m, e);
   endtask
   // polling is bounded so a stuck link ends the run
   task automatic poll(input logic [7:0] m);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 500 && (s & m) !== m; i++)
         rdv(8'h0E, s);
      if ((s & m) !== m)
      begin
         n_mismatch++;
         $display("Error at %0t: status %h expected %h", $time, s, m);
         complete_run();
      end
   endtask
   initial
   begin
      repeat (10) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      @(posedge CORE_CLK);
      rd(8'h0D, 8'h00, 8'hFF);
      rd(8'h20, 8'h00, 8'hFF);
      wr(8'h0D, 8'hFF);
      rd(8'h0D, 8'hFC, 8'hFF);
      wr(8'h0D, 8'h00);
      $display("test registers done");
      foreach (rows[i])
      begin
         wr(8'h0D, rows[i].ctl);
         wr(8'h12, rows[i].dir);
         wr(8'h11, rows[i].prt);
         wr(8'h0F, rows[i].dat);
         chk(pins_v & rows[i].msk, rows[i].exp);
      end
      $display("test pin rows done");
      wr(8'h0D, 8'h00);
      wr(8'h12, 8'h00);
      wr(8'h0E, 8'hE0);
      wr(8'h0F, 8'hA5);
      wr(8'h0D, 8'h12);
      chk({7'h0, PINS.do_o}, 8'h00);
      rd(8'h0F, 8'h4B, 8'hFF);
      rd(8'h0E, 8'h01, 8'h0F);
      wr(8'h0D, 8'h14);
      TIMER_MATCH <= 1'b1;
      @(posedge CORE_CLK);
      TIMER_MATCH <= 1'b0;
      @(posedge CORE_CLK);
      rd(8'h0F, 8'h97, 8'hFF);
      rd(8'h0E, 8'h02, 8'h0F);
      wr(8'h0E, 8'h0F);
      // leave the timer source first: a strobe is decoded against the stored source
      wr(8'h0D, 8'h10);
      wr(8'h0D, 8'h12);
      rd(8'h0E, 8'h40, 8'h4F);
      wr(8'h0E, 8'h00);
      rd(8'h0E, 8'h40, 8'h40);
      wr(8'h11, 8'h00);
      wr(8'h12, 8'h02);
      wr(8'h0D, 8'h11);
      rd(8'h11, 8'h02, 8'h03);
      wr(8'h0E, 8'hE0);
      wr(8'h0D, 8'h0B);
      // second write finds the select stored, so only the toggle strobe counts
      wr(8'h0D, 8'h0B);
      rd(8'h0E, 8'h02, 8'h0F);
      $display("test strobes done");
      for (int m = 0; m < 2; m++)
      begin
         wr(8'h12, 8'h02);
         wr(8'h11, 8'h03);
         wr(8'h0D, m ? 8'hB8 : 8'hA8);
         wr(8'h0E, 8'hE0);
         fm_tx <= m ? 8'h3A : 8'hC5;
         fm_go <= 1'b1;
         poll(8'h80);
         chk({7'h0, START_IRQ}, 8'h01);
         for (int i = 0; i < 50 && PINS.scl_oe !== 1'b1; i++)
            @(posedge CORE_CLK);
         chk({7'h0, PINS.scl_oe}, 8'h01);
         wr(8'h0E, 8'h80);
         fm_go <= 1'b0;
         poll(8'h40);
         rd(8'h0E, 8'h40, 8'hEF);
         rd(8'h0F, fm_tx, 8'hFF);
         chk({7'h0, PINS.scl_oe}, {7'h0, m[0]});
         chk({7'h0, OVF_IRQ}, 8'h00);
         wr(8'h0D, m ? 8'hF8 : 8'hE8);
         chk({7'h0, OVF_IRQ}, 8'h01);
         wr(8'h0E, 8'h40);
         chk({7'h0, PINS.scl_oe}, 8'h00);
         $display("test two-wire frame done");
      end
      complete_run();
   end
endmodule
`default_nettype wire

// *** testbench/usu_far_master.sv ***
`default_nettype none
module usu_far_master
(
   input  wire logic       go,
   input  wire logic [7:0] tx,
   input  wire logic       scl_in,
   output logic            scl,
   output logic            sda
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // ------
   // start condition, then eight bits msb first
   // ------
   always @(posedge go)
   begin
      #27 scl = 1'b1;
      #400 sda = 1'b0;
      #400 scl = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         #100 sda = tx[i];
         #300 scl = 1'b1;
         wait (scl_in);
         #413 scl = 1'b0;
      end
      #100 sda = 1'b1;
   end
endmodule
`default_nettype wire

// *** testbench/usu_serial_unit_asserts.sv ***
`default_nettype none
module usu_serial_unit_asserts
   import usu_pkg::*;
(
   input wire logic       CORE_CLK,
   input wire logic       RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic       GLOBAL_IE,
   input wire usu_pins_t  PINS,
   input wire logic       PULLUP_SDA,
   input wire logic       PULLUP_SCL,
   input wire logic       START_IRQ,
   input wire logic       OVF_IRQ
);
   logic [7:0] ctl_r;
   logic [7:0] dir_r;
   logic [1:0] prt_r;
   logic       clr_ovf;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   // ------
   // register shadows, kept from bus writes only
   // ------
   assign clr_ovf = WR && ADDR == 8'h0E && WDATA[6];
   always_ff @(posedge CORE_CLK)
      if (!RST_N)
         ctl_r <= 8'h00;
      else if (WR && ADDR == 8'h0D)
         ctl_r <= WDATA;
   always_ff @(posedge CORE_CLK)
      if (!RST_N)
         dir_r <= 8'h00;
      else if (WR && ADDR == 8'h12)
         dir_r <= WDATA;
   always_ff @(posedge CORE_CLK)
      if (!RST_N)
         prt_r <= 2'h0;
      else if (WR && ADDR == 8'h11)
         prt_r <= WDATA[1:0];
      else if (WR && ADDR == 8'h0D && WDATA[0])
         prt_r[1] <= !prt_r[1];
   sequence ctl_rd;
      RD && ADDR == 8'h0D;
   endsequence
   start_gate_a: assert property (START_IRQ |-> GLOBAL_IE && ctl_r[7])
      else $error("start irq without enable");
   ovf_gate_a: assert property (OVF_IRQ |-> GLOBAL_IE && ctl_r[6])
      else $error("overflow irq without enable");
   ovf_stays_a: assert property ($fell(OVF_IRQ) |-> !GLOBAL_IE || !ctl_r[6] || $past(clr_ovf))
      else $error("overflow irq dropped by itself");
   pullup_off_a: assert property (ctl_r[5] |-> !PULLUP_SDA && !PULLUP_SCL)
      else $error("pull-up on in two-wire mode");
   sda_quiet_a: assert property (!ctl_r[5] |-> !PINS.sda_oe)
      else $error("open-drain data driven outside two-wire");
   dir_gate_a: assert property (ctl_r[5] |-> (!PINS.sda_oe || dir_r[0])
      && (!PINS.scl_oe || dir_r[1]))
      else $error("open-drain driver without direction bit");
   sda_low_a: assert property (ctl_r[5] && dir_r[0] && !prt_r[0] |-> PINS.sda_oe)
      else $error("data line not pulled by port bit");
   scl_low_a: assert property (ctl_r[5] && dir_r[1] && !prt_r[1] |-> PINS.scl_oe)
      else $error("clock line not pulled by port bit");
   ctl_read_a: assert property (ctl_rd |=> RDATA == ($past(ctl_r) & 8'hFC))
      else $error("control read back wrong");
   toggle_inv_a: assert property (WR && ADDR == 8'h0D && WDATA[0] && WDATA[5:4] == 2'b01
      && ctl_r[5:4] == 2'b01 && PINS.scl_oe |=> PINS.scl_o != $past(PINS.scl_o))
      else $error("toggle strobe did not invert clock pin");
endmodule
bind usu_serial_unit usu_serial_unit_asserts u_chk (.CORE_CLK, .RST_N, .ADDR, .WDATA, .WR,
   .RD, .RDATA, .GLOBAL_IE, .PINS, .PULLUP_SDA, .PULLUP_SCL, .START_IRQ, .OVF_IRQ);
`default_nettype wire
